// ---- atc_defines.svh ----
`ifndef ATC_DEFINES_SVH
`define ATC_DEFINES_SVH

// trigger selector codes
`define ATC_SEL_ACQ        1'b0
`define ATC_SEL_FRM        1'b1
// trigger source codes
`define ATC_SRC_SW         2'h0
`define ATC_SRC_LINE1      2'h1
`define ATC_SRC_LINE2      2'h2
// activation codes
`define ATC_ACT_RISE       1'b0
`define ATC_ACT_FALL       1'b1
// run mode codes
`define ATC_RUN_SINGLE     1'b0
`define ATC_RUN_CONT       1'b1
// exposure mode codes
`define ATC_EXP_TIMED      1'b0
`define ATC_EXP_WIDTH      1'b1
// field widths
`define ATC_EXP_W          20
`define ATC_CNT_W          8
`define ATC_RD_W           16
// exposure duration unit: 1 us at 25 MHz
`define ATC_US_NS          1000
`define ATC_CLK_NS         40
`define ATC_US_CYC         (`ATC_US_NS / `ATC_CLK_NS)
// reset values
`define ATC_FCNT_RST       8'h01
`define ATC_EXP_RST        20'h00064

`endif

// ---- atc_pkg.sv ----
`include "atc_defines.svh"

package atc_pkg;
	// acquisition state, one-hot
	typedef enum logic [5:0] {
		ATC_IDLE     = 6'h01,
		ATC_WAIT_ACQ = 6'h02,
		ATC_WAIT_FRM = 6'h04,
		ATC_SETUP    = 6'h08,
		ATC_EXPOSE   = 6'h10,
		ATC_READOUT  = 6'h20
	} atc_state_t;

	// settings held per trigger
	typedef struct packed {
		logic       enable;
		logic [1:0] source;
		logic       activation;
	} atc_trig_cfg_t;
endpackage

// ---- atc_trig_if.sv ----
`timescale 1ns/1ns
`default_nettype none

// one trigger's settings and its recognised occurrence
interface atc_trig_if;
	import atc_pkg::*;
	atc_trig_cfg_t cfg;
	logic          sw_fire;
	logic          occur;
	logic          level;
	modport det (input cfg, input sw_fire, output occur, output level);
	modport ctl (output cfg, output sw_fire, input occur, input level);
endinterface

`default_nettype wire

// ---- atc_trig_det.sv ----
`timescale 1ns/1ns
`default_nettype none

// recognises occurrences of one trigger from software or a line
module atc_trig_det
	import atc_pkg::*;
(
	// clock and reset
	input  wire logic mclk_in,
	input  wire logic rst_in,
	// line inputs
	input  wire logic [1:0] line_in,
	// trigger side
	atc_trig_if.det   trig
);
	`include "atc_defines.svh"

	logic [1:0] line_q;
	logic [1:0] line_d;
	logic       occur_q;
	logic       occur_d;
	logic       level_q;
	logic       level_d;
	logic       cur;
	logic       prev;

	// pick the chosen line; level is polarity-corrected for width exposure
	always_comb begin
		line_d  = line_in;
		cur     = (trig.cfg.source == `ATC_SRC_LINE2) ? line_in[1] : line_in[0];
		prev    = (trig.cfg.source == `ATC_SRC_LINE2) ? line_q[1] : line_q[0];
		level_d = (trig.cfg.activation == `ATC_ACT_FALL) ? ~cur : cur;
		occur_d = 1'b0;
		if (trig.cfg.source == `ATC_SRC_SW) begin
			occur_d = trig.sw_fire; // [R1]
		end else if (trig.cfg.activation == `ATC_ACT_RISE) begin
			occur_d = cur & ~prev; // [R2] [R18]
		end else begin
			occur_d = ~cur & prev; // [R2] [R18]
		end
	end

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			line_q  <= 2'h0;
			occur_q <= 1'b0;
			level_q <= 1'b0;
		end else begin
			line_q  <= line_d;
			occur_q <= occur_d;
			level_q <= level_d;
		end
	end

	assign trig.occur = occur_q;
	assign trig.level = level_q;

	property p_sw_fire;
		@(posedge mclk_in) disable iff (rst_in)
		(trig.cfg.source == `ATC_SRC_SW && trig.sw_fire) |=> trig.occur;
	endproperty
	a_sw_fire: assert property (p_sw_fire) else $error("software fire lost"); // [R1]

	property p_rise;
		@(posedge mclk_in) disable iff (rst_in)
		(trig.cfg.source == `ATC_SRC_LINE2 && trig.cfg.activation == `ATC_ACT_RISE
			&& line_in[1] && !line_q[1]) |=> trig.occur;
	endproperty
	a_rise: assert property (p_rise) else $error("rising edge not seen"); // [R18]

	property p_fall;
		@(posedge mclk_in) disable iff (rst_in)
		(trig.cfg.source == `ATC_SRC_LINE1 && trig.cfg.activation == `ATC_ACT_FALL
			&& !line_in[0] && line_q[0]) |=> trig.occur;
	endproperty
	a_fall: assert property (p_fall) else $error("falling edge not seen"); // [R18]

endmodule

`default_nettype wire

// ---- atc_ctrl.sv ----
`timescale 1ns/1ns
`default_nettype none

//Function
// [R1] software command fires the selected software trigger
// [R2] line edge yields one trigger occurrence
// [R3] settings writes go to selected trigger
// [R4] software frame trigger uses exposure duration
// [R5] hardware frame trigger: timed or width
// [R6] timed mode ends after programmed duration
// [R7] width mode exposes while pulse active
// [R8] no frames before arm command
// [R9] halt when idle stops at once
// [R10] halt during frame waits for completion
// [R11] run mode: single frame or continuous
// [R12] single frame halts itself after frame
// [R13] continuous: one frame per accepted trigger
// [R14] continuous stays armed until halt
// [R15] single frame: setup each frame, no overlap
// [R16] frame triggers ignored unless waiting
// [R17] disabled trigger is generated internally
// [R18] polarity picks rising or falling edge
// [R19] count frames per acquisition-start occurrence
// [R20] halt during frame held pending
module atc_ctrl
	import atc_pkg::*;
(
	// clock and reset
	input  wire logic                 mclk_in,
	input  wire logic                 rst_in,
	// commands, one-cycle pulses
	input  wire logic                 arm_in,
	input  wire logic                 halt_in,
	input  wire logic                 sw_trig_in,
	input  wire logic                 cfg_wr_in,
	// shared trigger settings, written to the selected trigger
	input  wire logic                 trig_sel_in,
	input  wire logic                 trig_enable_in,
	input  wire logic [1:0]           trig_source_in,
	input  wire logic                 trig_activation_in,
	// global settings
	input  wire logic                 run_mode_in,
	input  wire logic                 exp_mode_in,
	input  wire logic [19:0]          exp_us_in,
	input  wire logic [7:0]           frame_count_in,
	input  wire logic [15:0]          readout_cyc_in,
	// hardware trigger lines
	input  wire logic [1:0]           line_in,
	// status and strobes
	output logic                      armed_out,
	output logic                      exposing_out,
	output logic                      frame_done_out,
	output logic                      wait_acq_out,
	output logic                      wait_frm_out
);
	`include "atc_defines.svh"

	atc_trig_if acq_if();
	atc_trig_if frm_if();

	atc_trig_det u_acq (
		.mclk_in (mclk_in),
		.rst_in  (rst_in),
		.line_in (line_in),
		.trig    (acq_if.det)
	);
	atc_trig_det u_frm (
		.mclk_in (mclk_in),
		.rst_in  (rst_in),
		.line_in (line_in),
		.trig    (frm_if.det)
	);

	atc_trig_cfg_t acq_cfg_q, acq_cfg_d, frm_cfg_q, frm_cfg_d;
	logic          sel_q, sel_d;

	// per-trigger settings; only the selected one is written
	always_comb begin
		acq_cfg_d = acq_cfg_q;
		frm_cfg_d = frm_cfg_q;
		sel_d     = sel_q;
		if (cfg_wr_in) begin
			sel_d = trig_sel_in;
			if (trig_sel_in == `ATC_SEL_ACQ) begin
				acq_cfg_d = '{trig_enable_in, trig_source_in, trig_activation_in}; // [R3]
			end else begin
				frm_cfg_d = '{trig_enable_in, trig_source_in, trig_activation_in}; // [R3]
			end
		end
	end

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			acq_cfg_q <= '0;
			frm_cfg_q <= '0;
			sel_q     <= `ATC_SEL_FRM;
		end else begin
			acq_cfg_q <= acq_cfg_d;
			frm_cfg_q <= frm_cfg_d;
			sel_q     <= sel_d;
		end
	end

	// software command goes only to the last selected trigger
	assign acq_if.cfg     = acq_cfg_q;
	assign frm_if.cfg     = frm_cfg_q;
	assign acq_if.sw_fire = sw_trig_in & (sel_q == `ATC_SEL_ACQ); // [R1]
	assign frm_if.sw_fire = sw_trig_in & (sel_q == `ATC_SEL_FRM); // [R1]

	// the exposure counter ticks once per microsecond
	logic [4:0] us_div_q, us_div_d;
	logic       us_tick;

	function automatic logic [4:0] atc_div_next(input logic [4:0] v);
		return (v == 5'(`ATC_US_CYC - 1)) ? 5'h00 : 5'(v + 5'h01);
	endfunction

	atc_state_t       st_q, st_d;
	logic             pend_halt_q, pend_halt_d;
	logic             armed_q, armed_d;
	logic [19:0]      exp_q, exp_d;
	logic [15:0]      rd_q, rd_d;
	logic [7:0]       fcnt_q, fcnt_d;
	logic             done_q, done_d;
	logic             hw_width;
	logic             frm_occ;
	// internal trigger generation when a trigger is switched off
	assign frm_occ  = frm_cfg_q.enable ? frm_if.occur : 1'b1; // [R17]
	assign hw_width = frm_cfg_q.enable && frm_cfg_q.source != `ATC_SRC_SW
		&& exp_mode_in == `ATC_EXP_WIDTH; // [R5]
	assign us_tick  = (us_div_q == 5'(`ATC_US_CYC - 1));

	// acquisition sequence
	always_comb begin
		st_d        = st_q;
		pend_halt_d = pend_halt_q;
		armed_d     = armed_q;
		exp_d       = exp_q;
		rd_d        = rd_q;
		fcnt_d      = fcnt_q;
		done_d      = 1'b0;
		us_div_d    = (st_q == ATC_EXPOSE) ? atc_div_next(us_div_q) : 5'h00;
		case (st_q)
			ATC_IDLE: begin
				if (arm_in) begin // [R8]
					armed_d = 1'b1;
					st_d    = acq_cfg_q.enable ? ATC_WAIT_ACQ : ATC_WAIT_FRM; // [R17]
				end
			end
			ATC_WAIT_ACQ: begin
				if (halt_in) begin
					armed_d = 1'b0; // [R9]
					st_d    = ATC_IDLE;
				end else if (acq_if.occur) begin
					fcnt_d = (frame_count_in == 8'h00) ? `ATC_FCNT_RST : frame_count_in; // [R19]
					st_d   = ATC_WAIT_FRM;
				end
			end
			ATC_WAIT_FRM: begin
				if (halt_in) begin
					armed_d = 1'b0; // [R9]
					st_d    = ATC_IDLE;
				end else if (frm_occ) begin // [R16]
					fcnt_d = fcnt_q - 8'h01; // [R19]
					st_d   = (run_mode_in == `ATC_RUN_SINGLE) ? ATC_SETUP : ATC_EXPOSE; // [R15]
					exp_d  = exp_us_in;
				end
			end
			ATC_SETUP: begin
				if (halt_in) pend_halt_d = 1'b1; // [R20]
				st_d = ATC_EXPOSE; // [R15]
			end
			ATC_EXPOSE: begin
				if (halt_in) pend_halt_d = 1'b1; // [R20]
				if (hw_width) begin
					if (!frm_if.level) st_d = ATC_READOUT; // [R7]
				end else if (exp_q == 20'h00000) begin
					st_d = ATC_READOUT; // [R4] [R6]
				end else if (us_tick) begin
					exp_d = exp_q - 20'h00001;
				end
				if (st_d == ATC_READOUT) rd_d = readout_cyc_in;
			end
			ATC_READOUT: begin
				if (halt_in) pend_halt_d = 1'b1; // [R20]
				if (rd_q != 16'h0000) begin
					rd_d = rd_q - 16'h0001; // [R15]
				end else begin
					done_d = 1'b1; // [R13]
					if (pend_halt_d || run_mode_in == `ATC_RUN_SINGLE) begin
						armed_d     = 1'b0; // [R10] [R12] [R11]
						pend_halt_d = 1'b0;
						st_d        = ATC_IDLE;
					end else if (acq_cfg_q.enable && fcnt_q == 8'h00) begin
						st_d = ATC_WAIT_ACQ; // [R19]
					end else begin
						st_d = ATC_WAIT_FRM; // [R14]
					end
				end
			end
			default: st_d = ATC_IDLE;
		endcase
	end

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			st_q        <= ATC_IDLE;
			pend_halt_q <= 1'b0;
			armed_q     <= 1'b0;
			exp_q       <= `ATC_EXP_RST;
			rd_q        <= 16'h0000;
			fcnt_q      <= `ATC_FCNT_RST;
			done_q      <= 1'b0;
			us_div_q    <= 5'h00;
		end else begin
			st_q        <= st_d;
			pend_halt_q <= pend_halt_d;
			armed_q     <= armed_d;
			exp_q       <= exp_d;
			rd_q        <= rd_d;
			fcnt_q      <= fcnt_d;
			done_q      <= done_d;
			us_div_q    <= us_div_d;
		end
	end

	// status outputs, all registered
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			armed_out      <= 1'b0;
			exposing_out   <= 1'b0;
			frame_done_out <= 1'b0;
			wait_acq_out   <= 1'b0;
			wait_frm_out   <= 1'b0;
		end else begin
			armed_out      <= armed_d;
			exposing_out   <= (st_d == ATC_EXPOSE);
			frame_done_out <= done_d;
			wait_acq_out   <= (st_d == ATC_WAIT_ACQ);
			wait_frm_out   <= (st_d == ATC_WAIT_FRM);
		end
	end

	sequence s_idle_trig;
		st_q == ATC_IDLE && !arm_in;
	endsequence
	property p_no_arm;
		@(posedge mclk_in) disable iff (rst_in)
		s_idle_trig |=> st_q == ATC_IDLE;
	endproperty
	a_no_arm: assert property (p_no_arm) else $error("left idle without arm"); // [R8]

	property p_halt_idle;
		@(posedge mclk_in) disable iff (rst_in)
		(st_q == ATC_WAIT_FRM && halt_in) |=> (st_q == ATC_IDLE && !armed_q);
	endproperty
	a_halt_idle: assert property (p_halt_idle) else $error("halt not immediate"); // [R9]

	property p_halt_busy;
		@(posedge mclk_in) disable iff (rst_in)
		(st_q == ATC_EXPOSE && halt_in) |=> pend_halt_q;
	endproperty
	a_halt_busy: assert property (p_halt_busy) else $error("halt not held"); // [R20]

	property p_pend_end;
		@(posedge mclk_in) disable iff (rst_in)
		(done_d && pend_halt_q) |=> (st_q == ATC_IDLE && !armed_q);
	endproperty
	a_pend_end: assert property (p_pend_end) else $error("pending halt ignored"); // [R10]

	property p_single;
		@(posedge mclk_in) disable iff (rst_in)
		(done_d && run_mode_in == `ATC_RUN_SINGLE) |=> !armed_q;
	endproperty
	a_single: assert property (p_single) else $error("single mode stayed armed"); // [R12]

	property p_cont;
		@(posedge mclk_in) disable iff (rst_in)
		(done_d && !pend_halt_q && !halt_in && run_mode_in == `ATC_RUN_CONT) |=> armed_q;
	endproperty
	a_cont: assert property (p_cont) else $error("continuous mode disarmed"); // [R14]

	property p_setup;
		@(posedge mclk_in) disable iff (rst_in)
		(st_q == ATC_WAIT_FRM && frm_occ && !halt_in && run_mode_in == `ATC_RUN_SINGLE)
			|=> st_q == ATC_SETUP ##1 st_q == ATC_EXPOSE;
	endproperty
	a_setup: assert property (p_setup) else $error("setup skipped"); // [R15]

	property p_ignore;
		@(posedge mclk_in) disable iff (rst_in)
		(st_q == ATC_WAIT_ACQ && !acq_if.occur && !halt_in) |=> st_q == ATC_WAIT_ACQ;
	endproperty
	a_ignore: assert property (p_ignore) else $error("frame trigger accepted early"); // [R16]

endmodule

`default_nettype wire

// ---- atc_trig_src.sv ----
`timescale 1ns/1ns
`default_nettype none

// external trigger source model: drives the hardware lines
module atc_trig_src (
	// clock
	input  wire logic       mclk_in,
	// lines toward the camera
	output var  logic [1:0] line_out
);
	// line1 idles high (falling use), line2 idles low (rising use)
	initial line_out = 2'h1;

	// one active pulse; its two edges frame the exposure
	task automatic pulse(input int idx, input int width);
		@(negedge mclk_in);
		line_out[idx] = ~line_out[idx];
		repeat (width) @(negedge mclk_in);
		line_out[idx] = ~line_out[idx];
	endtask
endmodule

`default_nettype wire

// ---- acquisition_trigger_control_bench.sv ----
`timescale 1ns/1ns
`default_nettype none

module acquisition_trigger_control_bench;
	logic        clk, rst, arm, halt, swt, wr, sel, en, act, run, expm;
	logic [1:0]  src, line;
	logic [19:0] exp_us;
	logic [7:0]  fcnt;
	logic        armed, expo, done, wacq, wfrm;
	int          num_errors, n_compared, n, seed;
	logic [31:0] expq[$];
	logic [31:0] lo_q[$];
	int          len, lo_v, hi_v;

	atc_ctrl dut (.mclk_in(clk), .rst_in(rst), .arm_in(arm), .halt_in(halt),
		.sw_trig_in(swt), .cfg_wr_in(wr), .trig_sel_in(sel), .trig_enable_in(en),
		.trig_source_in(src), .trig_activation_in(act), .run_mode_in(run),
		.exp_mode_in(expm), .exp_us_in(exp_us), .frame_count_in(fcnt),
		.readout_cyc_in(16'h0004), .line_in(line), .armed_out(armed),
		.exposing_out(expo), .frame_done_out(done), .wait_acq_out(wacq),
		.wait_frm_out(wfrm));
	atc_trig_src src_m (.mclk_in(clk), .line_out(line));

	initial begin
		clk = 0;
		forever #20 clk = ~clk;
	end

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask

	task give_verdict;
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// monitor: every finished frame takes the oldest expected exposure window
	always @(posedge clk) begin
		if (expo === 1'b1)
			len <= len + 1;
		if (done === 1'b1) begin
			len <= 0;
			if (expq.size() == 0)
				check("unexpected frame", 1, 0);
			else begin
				// pop both bounds first so the queues never drift apart
				lo_v = lo_q.pop_front();
				hi_v = expq.pop_front();
				check("exposure", len >= lo_v && len <= hi_v, 1);
			end
		end
	end

	// one-cycle command pulse, driven at the falling edge
	task automatic pulse(ref logic s);
		@(negedge clk);
		s = 1;
		@(negedge clk);
		s = 0;
	endtask

	task cfg(input logic t, input logic e, input logic [1:0] o, input logic a);
		sel = t;
		en = e;
		src = o;
		act = a;
		pulse(wr);
	endtask

	// bounded wait until a status equals the wanted level
	task wait_for(input int w, input logic v);
		for (n = 0; n < 3000; n++) begin
			@(posedge clk);
			#1;
			if ((w == 0 ? done : w == 1 ? wfrm : w == 2 ? wacq : armed) === v) begin
				// hand back on a falling edge so callers drive inputs there
				@(negedge clk);
				return;
			end
		end
		check("wait bound", 0, 1);
		give_verdict();
	endtask

	task note(input int lo, input int hi);
		lo_q.push_back(lo);
		expq.push_back(hi);
	endtask

	initial begin
		{arm, halt, swt, wr, sel, en, act, run, expm, src} = 0;
		seed = 32'h1a3d;
		num_errors = 0;
		n_compared = 0;
		len = 0;
		fcnt = 8'h02;
		exp_us = 20'h00001;
		rst = 1;
		repeat (5) @(posedge clk);
		@(negedge clk) rst = 0;
		// no frames without arm: software triggers land on nothing
		cfg(1, 1, 2'h0, 0);
		repeat (3) pulse(swt);
		repeat (40) @(negedge clk);
		check("armed idle", armed, 0);
		check("no wait state", {wacq, wfrm}, 2'h0);
		$display("test no_arm done");

		// single frame with internal frame trigger, then self-halt
		cfg(1, 0, 2'h0, 0);
		exp_us = 20'h1 + ($unsigned($random(seed)) % 3);
		note(exp_us * 25 + 1, exp_us * 25 + 1);
		pulse(arm);
		wait_for(0, 1);
		wait_for(3, 0);
		repeat (60) @(negedge clk);
		check("single stays halted", armed, 0);
		$display("test single done");

		// continuous, software frame trigger, back to back, extra trigger ignored
		run = 1;
		cfg(1, 1, 2'h0, 0);
		pulse(arm);
		for (int i = 0; i < 3; i++) begin
			exp_us = 20'h1 + ($unsigned($random(seed)) % 3);
			note(exp_us * 25 + 1, exp_us * 25 + 1);
			wait_for(1, 1);
			pulse(swt);
			repeat (4) @(negedge clk);
			pulse(swt);
			wait_for(0, 1);
		end
		check("continuous armed", armed, 1);
		pulse(halt);
		@(negedge clk);
		check("halt idle", armed, 0);
		pulse(swt);
		repeat (40) @(negedge clk);
		$display("test continuous done");

		// halt in mid-frame: frame completes, then acquisition stops
		note(exp_us * 25 + 1, exp_us * 25 + 1);
		pulse(arm);
		wait_for(1, 1);
		pulse(swt);
		repeat (6) @(negedge clk);
		pulse(halt);
		check("halt pended", armed, 1);
		wait_for(0, 1);
		repeat (2) @(negedge clk);
		check("halt after frame", armed, 0);
		$display("test halt_mid done");

		// width mode on line1, falling edge active
		expm = 1;
		cfg(1, 1, 2'h1, 1);
		pulse(arm);
		wait_for(1, 1);
		note(48, 53);
		src_m.pulse(0, 50);
		wait_for(0, 1);
		expm = 0;
		// timed mode on the same line
		note(exp_us * 25 + 1, exp_us * 25 + 1);
		wait_for(1, 1);
		src_m.pulse(0, 5);
		wait_for(0, 1);
		pulse(halt);
		$display("test hardware done");

		// acquisition start on line2 rising, two frames per start
		cfg(0, 1, 2'h2, 0);
		cfg(1, 1, 2'h0, 0);
		pulse(arm);
		wait_for(2, 1);
		pulse(swt);
		repeat (40) @(negedge clk);
		src_m.pulse(1, 3);
		for (int i = 0; i < 2; i++) begin
			note(exp_us * 25 + 1, exp_us * 25 + 1);
			wait_for(1, 1);
			pulse(swt);
			wait_for(0, 1);
		end
		wait_for(2, 1);
		check("back to acq wait", wacq, 1);
		pulse(swt);
		repeat (60) @(negedge clk);
		check("frames all seen", expq.size(), 0);
		// halt while waiting for acquisition start drops out at once
		pulse(halt);
		repeat (2) @(negedge clk);
		check("halt acq wait", {armed, wacq}, 2'h0);
		// software acquisition start routed by the selector
		cfg(0, 1, 2'h0, 0);
		pulse(arm);
		wait_for(2, 1);
		pulse(swt);
		wait_for(1, 1);
		check("sw acq start", wfrm, 1);
		$display("test acq_count done");
		give_verdict();
	end

	// hang guard
	initial begin
		#3000000;
		check("timeout", 0, 1);
		give_verdict();
	end
endmodule

`default_nettype wire
